// ===== dpbs_defines.vh
// constants for the dual partition boot swap controller
`ifndef DPBS_DEFINES_VH
`define DPBS_DEFINES_VH
// ***************************************************
// register byte offsets (axi4-lite)
// ***************************************************
`define DPBS_OFF_CTRL      12'h000
`define DPBS_OFF_KEY       12'h004
`define DPBS_OFF_ADDR      12'h008
`define DPBS_OFF_SWAP      12'h00c
`define DPBS_OFF_SEQ       12'h010
`define DPBS_OFF_MODE      12'h014
`define DPBS_OFF_BOOT_SEGMENT_LIMIT     12'h018
`define DPBS_OFF_SEGSEC    12'h01c
`define DPBS_OFF_IRQ_STAT  12'h020
`define DPBS_OFF_IRQ_MASK  12'h024
// ***************************************************
// flash control register fields
// ***************************************************
`define DPBS_CTRL_WR       15
`define DPBS_CTRL_SWDONE   13
`define DPBS_CTRL_P2ACT    12
`define DPBS_CTRL_ERRBIT   11
`define DPBS_CTRL_OP_HI    3
`define DPBS_CTRL_OP_LO    0
// operation select codes
`define DPBS_OP_ROW        4'h2
`define DPBS_OP_PAGE       4'h3
`define DPBS_OP_PART       4'h4
// ***************************************************
// keys, offsets, sequence word layout
// ***************************************************
`define DPBS_KEY1          8'h55
`define DPBS_KEY2          8'haa
`define DPBS_INACT_OFS     24'h400000
`define DPBS_SEQ_W         12
// mode register bits
`define DPBS_MODE_PROT     0
`define DPBS_MODE_PRIV     1
// irq bits: 0 op done, 1 swap done, 2 op refused
`define DPBS_IRQ_W         3
// timing
`define DPBS_CLK_NS        50
`define DPBS_ROW_NS        2000
`define DPBS_PAGE_NS       20000
`define DPBS_PART_NS       200000
`endif

// ===== dpbs_seq_pick.v
// boot partition selection from the two sequence words
`timescale 1ns/1ps
`include "dpbs_defines.vh"
module dpbs_seq_pick #(
   parameter SW = `DPBS_SEQ_W
) (
   input wire [2*SW-1:0] seq_word_p1,
   input wire [2*SW-1:0] seq_word_p2,
   output reg pick_p2
);
   // ***************************************************
   // validity and compare
   // ***************************************************
   wire v1 = (seq_word_p1[2*SW-1:SW] == ~seq_word_p1[SW-1:0]);
   wire v2 = (seq_word_p2[2*SW-1:SW] == ~seq_word_p2[SW-1:0]);
   // lower number wins, ties keep partition 1
   always @* begin
      if (v1 && v2)
         pick_p2 = (seq_word_p2[SW-1:0] < seq_word_p1[SW-1:0]);
      else if (v2)
         pick_p2 = 1'b1;
      else
         pick_p2 = 1'b0;
   end
endmodule // dpbs_seq_pick

// ===== dpbs_ctrl.v
// dual partition flash sequencer with axi4-lite registers
//
// Notes on behaviour
// - inactive partition erased/programmed, cpu not stalled
// - operation code erases whole inactive partition
// - inactive address = active address plus offset
// - 24-bit sequence word: number and complement
// - lower valid sequence number boots active
// - invalid complement; single valid wins, else one
// - unlocked swap exchanges partitions, no reset
// - swap honoured only after ordered key pair
// - swap without keys acts as no-operation
// - swap keeps peripherals, ram; ignores config
// - swap done flag and active partition flag
// - protected mode blocks writes to partition one
// - each partition has own security segments
// - privileged mode freezes boot segment limit
// - write start bit self-clears on completion
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dpbs_defines.vh"
module dpbs_ctrl #(
   parameter ROW_CYC = (`DPBS_ROW_NS + `DPBS_CLK_NS - 1) / `DPBS_CLK_NS,
   parameter PAGE_CYC = (`DPBS_PAGE_NS + `DPBS_CLK_NS - 1) / `DPBS_CLK_NS,
   parameter PART_CYC = (`DPBS_PART_NS + `DPBS_CLK_NS - 1) / `DPBS_CLK_NS,
   parameter BOOT_SEGMENT_LIMIT_W = 13
) (
   input wire CORE_CLK,
   input wire RST,
   input wire CLK_EN,
   input wire [23:0] SEQ_WORD_P1,
   input wire [23:0] SEQ_WORD_P2,
   input wire [11:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [11:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   output reg FLASH_BUSY,
   output reg FLASH_ERASE,
   output reg FLASH_PROG,
   output reg [23:0] FLASH_ADDR,
   output reg P2_ACTIVE,
   output reg IRQ
);
   // ***************************************************
   // state and registers
   // ***************************************************
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;
   localparam CW = 18;
   reg [1:0] st_r;
   reg [CW-1:0] cnt_r;
   reg [3:0] op_r;
   reg busy_r;
   reg swdone_r;
   reg err_r;
   reg p2act_r;
   reg [1:0] key_r; // 0 none, 1 first key seen, 2 unlocked
   reg [23:0] addr_r;
   reg [1:0] mode_r;
   reg mode_lock_r;
   reg [BOOT_SEGMENT_LIMIT_W-1:0] boot_segment_limit_r;
   reg [15:0] segsec_p1_r;
   reg [15:0] segsec_p2_r;
   reg [`DPBS_IRQ_W-1:0] ist_r;
   reg [`DPBS_IRQ_W-1:0] imask_r;
   reg boot_done_r;
   reg [1:0] wstate_r; // bit0 address held, bit1 data held
   reg [11:0] waddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   wire pick_p2;

   // boot selection from the two sequence words
   dpbs_seq_pick #(
      .SW(`DPBS_SEQ_W)
   ) u_pick (
      .seq_word_p1(SEQ_WORD_P1),
      .seq_word_p2(SEQ_WORD_P2),
      .pick_p2(pick_p2)
   );

   // cycles for an operation code
   function [CW-1:0] op_cycles;
      input [3:0] op;
      begin
         case (op)
            `DPBS_OP_ROW: op_cycles = ROW_CYC[CW-1:0];
            `DPBS_OP_PAGE: op_cycles = PAGE_CYC[CW-1:0];
            default: op_cycles = PART_CYC[CW-1:0];
         endcase
      end
   endfunction

   // start codes the sequencer knows; anything else is refused
   function op_valid;
      input [3:0] op;
      begin
         op_valid = (op == `DPBS_OP_ROW) || (op == `DPBS_OP_PAGE)
            || (op == `DPBS_OP_PART);
      end
   endfunction

   // ***************************************************
   // axi write channel capture
   // ***************************************************
   wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID && S_AXI_WREADY;
   wire [1:0] wst_nxt = wstate_r | {w_take, aw_take};
   wire wr_go = (wst_nxt == 2'b11) && !S_AXI_BVALID;
   wire [11:0] wa = aw_take ? S_AXI_AWADDR : waddr_r;
   wire [31:0] wd = w_take ? S_AXI_WDATA : wdata_r;
   wire [3:0] ws = w_take ? S_AXI_WSTRB : wstrb_r;
   wire [11:0] wa_w = {wa[11:2], 2'b00};
   wire wr_ctrl = wr_go && (wa_w == `DPBS_OFF_CTRL);
   wire wr_key = wr_go && (wa_w == `DPBS_OFF_KEY) && ws[0];
   wire wr_addr = wr_go && (wa_w == `DPBS_OFF_ADDR);
   wire wr_swap = wr_go && (wa_w == `DPBS_OFF_SWAP) && ws[0] && wd[0];
   wire wr_mode = wr_go && (wa_w == `DPBS_OFF_MODE);
   wire wr_boot_segment_limit = wr_go && (wa_w == `DPBS_OFF_BOOT_SEGMENT_LIMIT);
   wire wr_seg = wr_go && (wa_w == `DPBS_OFF_SEGSEC);
   wire wr_ist = wr_go && (wa_w == `DPBS_OFF_IRQ_STAT) && ws[0];
   wire wr_imask = wr_go && (wa_w == `DPBS_OFF_IRQ_MASK) && ws[0];
   wire wr_known = wr_ctrl | wr_key | wr_addr | (wr_go && (wa_w == `DPBS_OFF_SWAP))
      | wr_mode | wr_boot_segment_limit | wr_seg | (wr_go && (wa_w == `DPBS_OFF_IRQ_STAT))
      | (wr_go && (wa_w == `DPBS_OFF_IRQ_MASK)) | (wr_go && (wa_w == `DPBS_OFF_SEQ));
   wire start_req = wr_ctrl && ws[1] && wd[`DPBS_CTRL_WR] && !busy_r;

   // protected mode forbids anything that touches partition 1 on the inactive side
   wire p1_inactive = p2act_r;
   wire blocked = mode_r[`DPBS_MODE_PROT] && p1_inactive;
   wire [3:0] op_new = ws[0] ? wd[`DPBS_CTRL_OP_HI:`DPBS_CTRL_OP_LO] : op_r;
   wire start_ok = start_req && (key_r == 2'd2) && !blocked && op_valid(op_new);
   wire start_bad = start_req && !start_ok;
   wire swap_ok = wr_swap && (key_r == 2'd2) && !busy_r;
   wire op_end = (st_r == ST_RUN) && (cnt_r == {{(CW-1){1'b0}}, 1'b1});
   wire [`DPBS_IRQ_W-1:0] ev = {start_bad, swap_ok, op_end};

   // ***************************************************
   // axi handshake and response
   // ***************************************************
   // one write at a time: stop taking until response accepted
   always @(posedge CORE_CLK) begin
      if (RST) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'b00;
         wstate_r <= 2'b00;
         waddr_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else if (CLK_EN) begin
         if (aw_take)
            waddr_r <= S_AXI_AWADDR;
         if (w_take) begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            wstate_r <= 2'b00;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_known ? 2'b00 : 2'b10;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
         end else begin
            wstate_r <= wst_nxt;
            S_AXI_AWREADY <= !wst_nxt[0] && !S_AXI_BVALID;
            S_AXI_WREADY <= !wst_nxt[1] && !S_AXI_BVALID;
         end
         if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   // read path: one cycle to take, answer in the next
   always @(posedge CORE_CLK) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= 2'b00;
      end else if (CLK_EN) begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= 2'b00;
            case ({S_AXI_ARADDR[11:2], 2'b00})
               `DPBS_OFF_CTRL: S_AXI_RDATA <= {16'h0000, busy_r, 1'b0, swdone_r,
                  p2act_r, err_r, 7'h00, op_r};
               `DPBS_OFF_KEY: S_AXI_RDATA <= 32'h00000000; // key never reads back
               `DPBS_OFF_ADDR: S_AXI_RDATA <= {8'h00, addr_r};
               `DPBS_OFF_SWAP: S_AXI_RDATA <= 32'h00000000;
               `DPBS_OFF_SEQ: S_AXI_RDATA <= {8'h00, p2act_r ? SEQ_WORD_P2 : SEQ_WORD_P1};
               `DPBS_OFF_MODE: S_AXI_RDATA <= {29'h0, mode_lock_r, mode_r};
               `DPBS_OFF_BOOT_SEGMENT_LIMIT: S_AXI_RDATA <= {{(32-BOOT_SEGMENT_LIMIT_W){1'b0}}, boot_segment_limit_r};
               `DPBS_OFF_SEGSEC: S_AXI_RDATA <= {segsec_p2_r, segsec_p1_r};
               `DPBS_OFF_IRQ_STAT: S_AXI_RDATA <= {{(32-`DPBS_IRQ_W){1'b0}}, ist_r};
               `DPBS_OFF_IRQ_MASK: S_AXI_RDATA <= {{(32-`DPBS_IRQ_W){1'b0}}, imask_r};
               default: begin
                  S_AXI_RDATA <= 32'h00000000;
                  S_AXI_RRESP <= 2'b10;
               end
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ***************************************************
   // boot pick, unlock keys, swap
   // ***************************************************
   // sequence words are sampled one cycle after reset release
   always @(posedge CORE_CLK) begin
      if (RST) begin
         boot_done_r <= 1'b0;
         p2act_r <= 1'b0;
         swdone_r <= 1'b0;
         key_r <= 2'd0;
      end else if (CLK_EN) begin
         if (!boot_done_r) begin
            boot_done_r <= 1'b1;
            p2act_r <= pick_p2;
         end else if (swap_ok) begin
            p2act_r <= !p2act_r;
         end
         // config words are not re-read on a soft swap; ram etc untouched
         // set wins over a firmware clear in the same cycle
         if (swap_ok)
            swdone_r <= 1'b1;
         else if (wr_ctrl && ws[1] && !wd[`DPBS_CTRL_SWDONE])
            swdone_r <= 1'b0;
         // unlocked only by 55 then aa; anything else restarts
         if (start_req || wr_swap)
            key_r <= 2'd0;
         else if (wr_key)
            key_r <= (wd[7:0] == `DPBS_KEY1) ? 2'd1 :
               ((wd[7:0] == `DPBS_KEY2) && key_r == 2'd1) ? 2'd2 : 2'd0;
      end
   end

   // ***************************************************
   // operation sequencer
   // ***************************************************
   // runs beside the cpu: the bus never waits on a busy flash
   always @(posedge CORE_CLK) begin
      if (RST) begin
         st_r <= ST_IDLE;
         cnt_r <= {CW{1'b0}};
         busy_r <= 1'b0;
         op_r <= 4'h0;
         err_r <= 1'b0;
         addr_r <= 24'h000000;
      end else if (CLK_EN) begin
         if (wr_addr)
            addr_r <= wd[23:0];
         if (wr_ctrl && ws[0] && !busy_r)
            op_r <= wd[`DPBS_CTRL_OP_HI:`DPBS_CTRL_OP_LO];
         if (start_bad)
            err_r <= 1'b1;
         else if (start_ok)
            err_r <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (start_ok) begin
                  st_r <= ST_RUN;
                  busy_r <= 1'b1;
                  cnt_r <= op_cycles(op_new);
               end
            end
            ST_RUN: begin
               cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
               if (op_end) begin
                  st_r <= ST_IDLE;
                  busy_r <= 1'b0;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
   // ***************************************************
   // modes, segment limit, security segments
   // ***************************************************
   // mode bits set once and then lock until reset
   always @(posedge CORE_CLK) begin
      if (RST) begin
         mode_r <= 2'b00;
         mode_lock_r <= 1'b0;
         boot_segment_limit_r <= {BOOT_SEGMENT_LIMIT_W{1'b0}};
         segsec_p1_r <= 16'h0000;
         segsec_p2_r <= 16'h0000;
      end else if (CLK_EN) begin
         if (wr_mode && !mode_lock_r) begin
            mode_r <= wd[1:0];
            mode_lock_r <= 1'b1;
         end
         if (wr_boot_segment_limit && !mode_r[`DPBS_MODE_PRIV])
            boot_segment_limit_r <= wd[BOOT_SEGMENT_LIMIT_W-1:0];
         if (wr_seg && ws[0] && ws[1])
            segsec_p1_r <= wd[15:0];
         if (wr_seg && ws[2] && ws[3])
            segsec_p2_r <= wd[31:16];
      end
   end

   // ***************************************************
   // interrupts and outputs
   // ***************************************************
   // write one to clear; a new event in the same cycle stays set
   always @(posedge CORE_CLK) begin
      if (RST) begin
         ist_r <= {`DPBS_IRQ_W{1'b0}};
         imask_r <= {`DPBS_IRQ_W{1'b0}};
         IRQ <= 1'b0;
         FLASH_BUSY <= 1'b0;
         FLASH_ERASE <= 1'b0;
         FLASH_PROG <= 1'b0;
         FLASH_ADDR <= 24'h000000;
         P2_ACTIVE <= 1'b0;
      end else if (CLK_EN) begin
         ist_r <= (ist_r & ~(wr_ist ? wd[`DPBS_IRQ_W-1:0] : {`DPBS_IRQ_W{1'b0}})) | ev;
         if (wr_imask)
            imask_r <= wd[`DPBS_IRQ_W-1:0];
         IRQ <= |(((ist_r & ~(wr_ist ? wd[`DPBS_IRQ_W-1:0] : {`DPBS_IRQ_W{1'b0}}))
            | ev) & (wr_imask ? wd[`DPBS_IRQ_W-1:0] : imask_r));
         FLASH_BUSY <= busy_r;
         FLASH_ERASE <= busy_r && (op_r != `DPBS_OP_ROW);
         FLASH_PROG <= busy_r && (op_r == `DPBS_OP_ROW);
         FLASH_ADDR <= addr_r + `DPBS_INACT_OFS;
         P2_ACTIVE <= p2act_r;
      end
   end
endmodule // dpbs_ctrl

// ===== dpbs_ctrl_props.sv
// concurrent assertions for the dual partition boot swap controller
`timescale 1ns/1ps
module dpbs_ctrl_props #(
   parameter int PART_CYC = 4000
) (
   input wire CORE_CLK,
   input wire RST,
   input wire CLK_EN,
   input wire [23:0] SEQ_WORD_P1,
   input wire [23:0] SEQ_WORD_P2,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire FLASH_BUSY,
   input wire FLASH_ERASE,
   input wire FLASH_PROG,
   input wire P2_ACTIVE
);
   // ****************************************
   // helper logic
   // ****************************************
   localparam int BUSY_MAX = PART_CYC + 4;
   int busy_len;
   // enabled cycles spent busy; a counter because the longest run is far too long for a range
   always @(posedge CORE_CLK) begin
      if (RST || !FLASH_BUSY)
         busy_len <= 0;
      else if (CLK_EN)
         busy_len <= busy_len + 1;
   end
   // a word is valid when its upper half complements its lower half
   wire ok_p1 = (SEQ_WORD_P1[23:12] == ~SEQ_WORD_P1[11:0]);
   wire ok_p2 = (SEQ_WORD_P2[23:12] == ~SEQ_WORD_P2[11:0]);
   // ties stay on partition one, so only a strictly lower number wins
   wire want_p2 = ok_p2 && (!ok_p1 || (SEQ_WORD_P2[11:0] < SEQ_WORD_P1[11:0]));
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   // an operation runs a few cycles, then must end within the longest count
   sequence s_busy_min;
      FLASH_BUSY [*3];
   endsequence
   // ****************************************
   // assertions
   // ****************************************
   AST_BOOT_PICK: assert property ($fell(RST) |-> ##2 (P2_ACTIVE == want_p2))
      else $error("boot partition pick wrong");
   AST_BUSY_RUN: assert property ($rose(FLASH_BUSY) |-> s_busy_min)
      else $error("operation too short");
   AST_BUSY_END: assert property (FLASH_BUSY |-> (busy_len < BUSY_MAX))
      else $error("operation did not end");
   AST_BUSY_KIND: assert property (FLASH_BUSY |-> (FLASH_ERASE != FLASH_PROG))
      else $error("busy without exactly one kind");
   AST_IDLE_KIND: assert property (!FLASH_BUSY |-> !FLASH_ERASE && !FLASH_PROG)
      else $error("erase or program while idle");
   AST_B_AFTER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |=> S_AXI_BVALID)
      else $error("write response late");
   AST_R_AFTER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read response dropped or changed");
   AST_W_REFUSE: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   AST_AR_REFUSE: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while response pending");
endmodule // dpbs_ctrl_props
bind dpbs_ctrl dpbs_ctrl_props #(.PART_CYC(PART_CYC)) u_props (
   .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN),
   .SEQ_WORD_P1(SEQ_WORD_P1), .SEQ_WORD_P2(SEQ_WORD_P2),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .FLASH_BUSY(FLASH_BUSY), .FLASH_ERASE(FLASH_ERASE), .FLASH_PROG(FLASH_PROG),
   .P2_ACTIVE(P2_ACTIVE));

// ===== dpbs_ctrl_bench.sv
// self-checking bench for the dual partition boot swap controller
`timescale 1ns/1ps
`include "dpbs_defines.vh"
module dpbs_ctrl_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [23:0] seq1 = 24'h0, seq2 = 24'h0, ad;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rv;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, busy, erase, prog, p2act, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] faddr;
   logic [1:0] rr;
   int miscompares = 0;
   int samples_checked = 0;
   // boot table: partition words and expected pick
   logic [23:0] bt1 [6] = '{24'hffa005, 24'hffc003, 24'h123456, 24'hff6009, 24'h0, 24'hffa005};
   logic [23:0] bt2 [6] = '{24'hffc003, 24'hffa005, 24'hff6009, 24'h0, 24'h123456, 24'hffa005};
   logic bexp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [3:0] ops [3] = '{`DPBS_OP_ROW, `DPBS_OP_PAGE, `DPBS_OP_PART};
   logic [1:0] kexp [3] = '{2'b10, 2'b01, 2'b01};
   // 50 ns period
   always #25 clk = ~clk;
   // counts kept short so the row op outlasts one register read
   dpbs_ctrl #(.ROW_CYC(8), .PAGE_CYC(10), .PART_CYC(12)) u_dpbs_ctrl (
      .CORE_CLK(clk), .RST(rst), .CLK_EN(clk_en), .SEQ_WORD_P1(seq1), .SEQ_WORD_P2(seq2),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .FLASH_BUSY(busy), .FLASH_ERASE(erase), .FLASH_PROG(prog), .FLASH_ADDR(faddr),
      .P2_ACTIVE(p2act), .IRQ(irq));
   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // address and data go out together and are released one by one
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
      input logic [1:0] er = 2'b00);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // ready raised late on purpose so the response must wait
      do @(posedge clk); while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      check({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic unlock();
      wr(`DPBS_OFF_KEY, {24'h0, `DPBS_KEY1});
      wr(`DPBS_OFF_KEY, {24'h0, `DPBS_KEY2});
   endtask
   task automatic do_reset(input logic [23:0] s1, input logic [23:0] s2);
      seq1 <= s1;
      seq2 <= s2;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      for (int i = 0; i < 6; i++) begin
         do_reset(bt1[i], bt2[i]);
         check({31'h0, p2act}, {31'h0, bexp[i]});
         rd(`DPBS_OFF_SEQ);
         check(rv, {8'h0, bexp[i] ? bt2[i] : bt1[i]});
      end
      // unmapped places answer with a slave error
      rd(12'h028);
      check({rr, rv[29:0]}, 32'h80000000);
      wr(12'h02c, 32'h1, 4'hf, 2'b10);
      // start without keys and with keys in the wrong order
      wr(`DPBS_OFF_ADDR, 32'h012340);
      wr(`DPBS_OFF_CTRL, 32'h8002);
      rd(`DPBS_OFF_CTRL);
      check({27'h0, rv[15:11]}, 32'h1);
      check({31'h0, busy}, 32'h0);
      wr(`DPBS_OFF_IRQ_MASK, 32'h4);
      check({31'h0, irq}, 32'h1);
      wr(`DPBS_OFF_IRQ_STAT, 32'h4);
      check({31'h0, irq}, 32'h0);
      wr(`DPBS_OFF_KEY, 32'haa);
      wr(`DPBS_OFF_KEY, 32'h55);
      wr(`DPBS_OFF_CTRL, 32'h8002);
      rd(`DPBS_OFF_IRQ_STAT);
      check(rv, 32'h4);
      wr(`DPBS_OFF_IRQ_STAT, 32'h4);
      // each operation code on the inactive partition
      for (int i = 0; i < 3; i++) begin
         ad = 24'h012340 + 24'(i);
         wr(`DPBS_OFF_ADDR, {8'h0, ad});
         unlock();
         wr(`DPBS_OFF_CTRL, {16'h0, 12'h800, ops[i]});
         check({31'h0, busy}, 32'h1);
         check({8'h0, faddr}, {8'h0, ad + `DPBS_INACT_OFS});
         check({30'h0, prog, erase}, {30'h0, kexp[i]});
         // a low enable holds the run where it stands
         if (i == 0) begin
            clk_en <= 1'b0;
            repeat (20) @(posedge clk);
            check({31'h0, busy}, 32'h1);
            clk_en <= 1'b1;
         end
         rd(`DPBS_OFF_CTRL);
         check({31'h0, rv[15]}, 32'h1);
         rv = 32'hffffffff;
         for (int n = 0; n < 40 && rv[15]; n++) rd(`DPBS_OFF_CTRL);
         check({31'h0, rv[15]}, 32'h0);
         rd(`DPBS_OFF_IRQ_STAT);
         check(rv, 32'h1);
         check({31'h0, irq}, 32'h0); // done bit is masked off
         wr(`DPBS_OFF_IRQ_STAT, 32'h1);
      end
      // unlock is used up by the last start
      wr(`DPBS_OFF_CTRL, 32'h8002);
      rd(`DPBS_OFF_IRQ_STAT);
      check(rv, 32'h4);
      wr(`DPBS_OFF_IRQ_STAT, 32'h7);
      // unlocked start with a code the sequencer does not know
      unlock();
      wr(`DPBS_OFF_CTRL, 32'h8005);
      rd(`DPBS_OFF_IRQ_STAT);
      check(rv, 32'h4);
      check({31'h0, busy}, 32'h0);
      wr(`DPBS_OFF_IRQ_STAT, 32'h4);
      // swap without keys, then with keys
      wr(`DPBS_OFF_SEGSEC, 32'hbeef1234);
      wr(`DPBS_OFF_SWAP, 32'h1);
      rd(`DPBS_OFF_CTRL);
      check({30'h0, rv[13:12]}, 32'h0);
      wr(`DPBS_OFF_IRQ_MASK, 32'h0);
      unlock();
      wr(`DPBS_OFF_SWAP, 32'h1);
      check({31'h0, irq}, 32'h0);
      rd(`DPBS_OFF_CTRL);
      check({30'h0, rv[13:12]}, 32'h3);
      check({31'h0, p2act}, 32'h1);
      rd(`DPBS_OFF_SEGSEC);
      check(rv, 32'hbeef1234);
      wr(`DPBS_OFF_CTRL, 32'h0, 4'h2);
      rd(`DPBS_OFF_CTRL);
      check({31'h0, rv[13]}, 32'h0);
      // mode is write-once; limit frozen, partition one kept safe
      wr(`DPBS_OFF_BOOT_SEGMENT_LIMIT, 32'h0123);
      wr(`DPBS_OFF_MODE, 32'h3);
      wr(`DPBS_OFF_BOOT_SEGMENT_LIMIT, 32'h0456);
      rd(`DPBS_OFF_BOOT_SEGMENT_LIMIT);
      check(rv, 32'h0123);
      wr(`DPBS_OFF_MODE, 32'h0);
      rd(`DPBS_OFF_MODE);
      check(rv, 32'h7);
      unlock();
      wr(`DPBS_OFF_CTRL, 32'h8003);
      rd(`DPBS_OFF_CTRL);
      check({27'h0, rv[15:11]}, 32'h3);
      check({31'h0, busy}, 32'h0);
      results();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end
endmodule // dpbs_ctrl_bench
